// File: include/clm_pkg.sv
// Shared constants and types for the clock-loss and clock-mode control block
package clm_pkg;

	// Register bus geometry
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_CONTROL_REG_ONE = 2'h0;
	localparam logic [ADDR_W-1:0] OFS_CONTROL_REG_TWO = 2'h1;
	localparam logic [ADDR_W-1:0] OFS_STATUS_REG_ONE  = 2'h2;
	localparam logic [ADDR_W-1:0] OFS_STATUS_REG_TWO  = 2'h3;

	// Control register one fields
	localparam int C1_RANGE_BIT       = 6;
	localparam int C1_REF_SELECT_BIT  = 5;
	localparam int C1_MODE_SEL_HI     = 4;
	localparam int C1_MODE_SEL_LO     = 3;
	localparam int C1_LOSS_CLK_DIS_BIT = 1;

	// Control register two fields
	localparam int C2_LOSS_LOCK_RST_BIT = 7;
	localparam int C2_MULT_HI           = 6;
	localparam int C2_MULT_LO           = 4;
	localparam int C2_LOSS_CLK_RST_BIT  = 3;
	localparam int C2_RDIV_HI           = 2;
	localparam int C2_RDIV_LO           = 0;

	// Status register one fields
	localparam int S1_MODE_ST_HI      = 7;
	localparam int S1_MODE_ST_LO      = 6;
	localparam int S1_REF_TYPE_BIT    = 5;
	localparam int S1_LOSS_LOCK_BIT   = 4;
	localparam int S1_LOCK_BIT        = 3;
	localparam int S1_LOSS_CLK_BIT    = 2;
	localparam int S1_EXT_REF_OK_BIT  = 1;
	localparam int S1_IRQ_FLAG_BIT    = 0;

	// Status register two fields
	localparam int S2_OSC_STABLE_BIT  = 0;

	// Values after reset
	localparam logic [1:0] MODE_SEL_RST   = 2'h0;
	localparam logic [2:0] MULT_RST       = 3'h0;
	localparam logic [2:0] RDIV_RST       = 3'h0;

	// Bus cycles between a mode-select write and the mode-status update
	localparam logic [2:0] MODE_SETTLE_CYC = 3'h4;

	// Comparison cycle lengths in reference periods
	localparam logic [7:0] CMP_INT_PERIODS   = 8'h08;
	localparam logic [7:0] CMP_EXT_LO_PERIODS = 8'h02;
	localparam logic [7:0] CMP_EXT_HI_PERIODS = 8'h80;
	// Internal reference predivide used by the comparisons
	localparam logic [2:0] INT_REF_PREDIV     = 3'h7;

	// Mode-select request encodings
	localparam logic [1:0] SEL_SELF_CLOCKED  = 2'h0;
	localparam logic [1:0] SEL_ENG_INTERNAL  = 2'h1;
	localparam logic [1:0] SEL_BYP_EXTERNAL  = 2'h2;
	localparam logic [1:0] SEL_ENG_EXTERNAL  = 2'h3;

	// Output clock source encodings
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_OSC  = 2'h1;
	localparam logic [1:0] SRC_EXT  = 2'h2;

	// Actual mode; the low two bits are the reported mode status
	typedef enum logic [2:0] {
		MD_SELF_CLOCKED = 3'b000,
		MD_ENG_INTERNAL = 3'b001,
		MD_BYP_EXTERNAL = 3'b010,
		MD_ENG_EXTERNAL = 3'b011,
		MD_OFF          = 3'b100
	} clm_mode_t;

endpackage : clm_pkg

// File: rtl/clm_ctrl.sv
// Loss-of-clock supervision and clock-mode control top level
// How it works
// - Monitored clock too slow sets loss flag
// - Loss flag sticky until clear or reset
// - Clear by status read then flag write
// - Engaged-external falls back on either loss
// - Bypassed-external falls to self-clocked on loss
// - Fallback rewrites both select and status
// - Clock loss in engaged modes loses lock
// - Lock reset overrides clock-loss interrupt
// - Reference ok only when fast enough, except bypass selected with ref type clear
// - Reference ok forced per select and type
// - Oscillator monitored only in running modes
// - Off mode monitors during crystal start-up only with bypass selected and ref type set
// - Select requests mode, status reports it
// - Status updates several cycles after write
// - First write fixes reference select
// - Requested mode held off until ready
// - Output clock source, divider, comparison length
// - Engaged-external halves clock while locking
// - Self-clocked compares against internal reference
// - Lock-loss flag cleared like clock flag
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module clm_ctrl
	import clm_pkg::*;
(
	input  wire logic                      sys_clk_i,
	input  wire logic                      reset_n_i,
	input  wire logic                      ce_i,
	input  wire logic [clm_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [clm_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic      [clm_pkg::DATA_W-1:0] rdata_o,
	input  wire logic                      ext_ref_low_i,
	input  wire logic                      osc_low_i,
	input  wire logic                      osc_stable_i,
	input  wire logic                      xtal_startup_i,
	input  wire logic                      stop_i,
	input  wire logic                      lock_i,
	input  wire logic                      lock_lost_i,
	output logic      [1:0]                gen_clk_src_o,
	output logic      [2:0]                gen_clk_rdiv_o,
	output logic                           gen_clk_half_o,
	output logic                           cmp_ref_ext_o,
	output logic      [7:0]                cmp_periods_o,
	output logic      [2:0]                int_ref_prediv_o,
	output logic      [2:0]                mult_factor_field_o,
	output logic                           irq_o,
	output logic                           reset_req_o
);

	clm_mode_t  mode_r;
	clm_mode_t  mode_nxt;
	logic [1:0] mode_select_r;
	logic       range_r;
	logic       ref_select_r;
	logic       loss_clock_disable_r;
	logic       first_write_done_r;
	logic       loss_lock_reset_en_r;
	logic       loss_clock_reset_en_r;
	logic [2:0] mult_factor_field_r;
	logic [2:0] rdiv_r;
	logic       loss_clock_flag_r;
	logic       loss_lock_flag_r;
	logic       status_read_armed_r;
	logic       osc_wait_r;
	logic [2:0] settle_cnt_r;
	logic       lock_half_r;
	logic [DATA_W-1:0] rdata_r;
	logic       reset_req_r;
	logic       reset_cond;
	logic       ext_ref_ok;
	logic       ref_mon;
	logic       osc_mon;
	logic       ref_loss;
	logic       osc_loss;
	logic       clock_loss;
	logic       wr_ctrl1;
	logic       wr_ctrl2;
	logic       flag_clear;
	logic       fallback;
	logic       request_ok;
	logic [DATA_W-1:0] status_one;
	logic [DATA_W-1:0] status_two;
	// Monitoring enables and reference-ok level
	clm_monitor u_monitor (
		.mode_i               (mode_r),
		.mode_select_i        (mode_select_r),
		.ref_type_status_i    (ref_select_r),
		.loss_clock_disable_i (loss_clock_disable_r),
		.xtal_startup_i       (xtal_startup_i),
		.ext_ref_low_i        (ext_ref_low_i),
		.osc_wait_i           (osc_wait_r),
		.ext_ref_ok_o         (ext_ref_ok),
		.ref_mon_o            (ref_mon),
		.osc_mon_o            (osc_mon)
	);
	// Register write decode
	assign wr_ctrl1 = wr_i && (addr_i == OFS_CONTROL_REG_ONE);
	assign wr_ctrl2 = wr_i && (addr_i == OFS_CONTROL_REG_TWO);
	assign ref_loss   = ref_mon && ext_ref_low_i;
	assign osc_loss   = osc_mon && osc_low_i;
	assign clock_loss = ref_loss || osc_loss;
	assign flag_clear = wr_i && (addr_i == OFS_STATUS_REG_ONE) && wdata_i[S1_IRQ_FLAG_BIT] && status_read_armed_r;
	assign fallback = (mode_r == MD_ENG_EXTERNAL && clock_loss) || (mode_r == MD_BYP_EXTERNAL && ref_loss);
	assign request_ok = (settle_cnt_r == 3'h0);
	// Control register one; mode select also rewritten by fallbacks
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mode_select_r        <= MODE_SEL_RST;
			range_r              <= 1'b0;
			ref_select_r         <= 1'b0;
			loss_clock_disable_r <= 1'b0;
			first_write_done_r   <= 1'b0;
		end
		else if (ce_i)
		begin
			if (mode_r == MD_ENG_EXTERNAL && ref_loss)
				mode_select_r <= SEL_SELF_CLOCKED;
			else if (mode_r == MD_ENG_EXTERNAL && osc_loss)
				mode_select_r <= SEL_BYP_EXTERNAL;
			else if (mode_r == MD_BYP_EXTERNAL && ref_loss)
				mode_select_r <= SEL_SELF_CLOCKED;
			else if (wr_ctrl1)
				mode_select_r <= wdata_i[C1_MODE_SEL_HI:C1_MODE_SEL_LO];
			if (wr_ctrl1)
			begin
				range_r              <= wdata_i[C1_RANGE_BIT];
				loss_clock_disable_r <= wdata_i[C1_LOSS_CLK_DIS_BIT];
				first_write_done_r   <= 1'b1;
			end
			// reference select fixed by first write
			if (wr_ctrl1 && !first_write_done_r)
				ref_select_r <= wdata_i[C1_REF_SELECT_BIT] && wdata_i[C1_MODE_SEL_HI];
		end
	end
	// Control register two
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			loss_lock_reset_en_r  <= 1'b0;
			loss_clock_reset_en_r <= 1'b0;
			mult_factor_field_r   <= MULT_RST;
			rdiv_r                <= RDIV_RST;
		end
		else if (ce_i && wr_ctrl2)
		begin
			loss_lock_reset_en_r  <= wdata_i[C2_LOSS_LOCK_RST_BIT];
			mult_factor_field_r   <= wdata_i[C2_MULT_HI:C2_MULT_LO];
			loss_clock_reset_en_r <= wdata_i[C2_LOSS_CLK_RST_BIT];
			rdiv_r                <= wdata_i[C2_RDIV_HI:C2_RDIV_LO];
		end
	end
	// settle counter after a mode-select write
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			settle_cnt_r <= 3'h0;
		else if (ce_i)
		begin
			if (wr_ctrl1)
				settle_cnt_r <= MODE_SETTLE_CYC;
			else if (settle_cnt_r != 3'h0)
				settle_cnt_r <= settle_cnt_r - 3'h1;
		end
	end
	// Next mode: fallbacks act at once, requests wait for settle and preconditions
	always_comb
	begin
		mode_nxt = mode_r;
		case (mode_r)
			MD_OFF:
			begin
				if (!stop_i)
				begin
					if (mode_select_r == SEL_BYP_EXTERNAL)
						mode_nxt = ext_ref_ok ? MD_BYP_EXTERNAL : MD_OFF;
					else
						mode_nxt = MD_SELF_CLOCKED;
				end
			end
			MD_ENG_EXTERNAL:
			begin
				if (ref_loss)
					mode_nxt = MD_SELF_CLOCKED;
				else if (osc_loss)
					mode_nxt = MD_BYP_EXTERNAL;
				else if (request_ok)
					mode_nxt = clm_mode_t'({1'b0, mode_select_r});
			end
			MD_BYP_EXTERNAL:
			begin
				if (ref_loss)
					mode_nxt = MD_SELF_CLOCKED;
				else if (request_ok)
					mode_nxt = clm_mode_t'({1'b0, mode_select_r});
			end
			MD_SELF_CLOCKED,
			MD_ENG_INTERNAL:
			begin
				if (request_ok)
					mode_nxt = clm_mode_t'({1'b0, mode_select_r});
			end
			default:
				mode_nxt = MD_SELF_CLOCKED;
		endcase
		if (mode_nxt != mode_r && mode_r != MD_OFF && !fallback)
		begin
			case (mode_nxt)
				MD_ENG_INTERNAL:
					if (!osc_stable_i)
						mode_nxt = mode_r;
				MD_BYP_EXTERNAL:
					if (!ext_ref_ok)
						mode_nxt = mode_r;
				MD_ENG_EXTERNAL:
					if (!osc_stable_i || !ext_ref_ok ||
						(mode_r == MD_BYP_EXTERNAL && loss_clock_flag_r))
						mode_nxt = mode_r;
				default:
					mode_nxt = mode_nxt;
			endcase
		end
		// Stop request takes the generator off from any mode
		if (stop_i)
			mode_nxt = MD_OFF;
	end
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			mode_r <= MD_SELF_CLOCKED;
		else if (ce_i)
			mode_r <= mode_nxt;
	end
	// oscillator check waits for stability after entry to self-clocked from off or bypass
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			osc_wait_r <= 1'b0;
		else if (ce_i)
		begin
			if (mode_nxt == MD_SELF_CLOCKED && (mode_r == MD_OFF || mode_r == MD_BYP_EXTERNAL))
				osc_wait_r <= 1'b1;
			else if (osc_stable_i)
				osc_wait_r <= 1'b0;
		end
	end
	// sticky loss-of-clock flag, set beats clear
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			loss_clock_flag_r <= 1'b0;
		else if (ce_i)
		begin
			if (clock_loss)
				loss_clock_flag_r <= 1'b1;
			// software clear only without reset enable
			else if (flag_clear && !loss_clock_reset_en_r)
				loss_clock_flag_r <= 1'b0;
		end
	end
	// loss of lock flag, also set by clock loss when engaged
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			loss_lock_flag_r <= 1'b0;
		else if (ce_i)
		begin
			if (lock_lost_i || (clock_loss && (mode_r == MD_ENG_INTERNAL || mode_r == MD_ENG_EXTERNAL)))
				loss_lock_flag_r <= 1'b1;
			else if (flag_clear && !loss_lock_reset_en_r)
				loss_lock_flag_r <= 1'b0;
		end
	end
	// arm the clear on a status register read
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			status_read_armed_r <= 1'b0;
		else if (ce_i)
		begin
			if (rd_i && addr_i == OFS_STATUS_REG_ONE)
				status_read_armed_r <= 1'b1;
			else if (flag_clear)
				status_read_armed_r <= 1'b0;
		end
	end
	// reset request; the resulting system reset clears both flags
	assign reset_cond = (loss_clock_flag_r && loss_clock_reset_en_r) || (loss_lock_flag_r && loss_lock_reset_en_r);
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			reset_req_r <= 1'b0;
		else if (ce_i)
			reset_req_r <= reset_cond;
	end
	// lock reset masks the interrupt from the flag's first cycle, no one-cycle glitch
	assign irq_o = !reset_cond && !reset_req_r &&
		((loss_clock_flag_r && !loss_clock_reset_en_r) || (loss_lock_flag_r && !loss_lock_reset_en_r));
	assign reset_req_o = reset_req_r;
	// half rate until lock after entry or multiplier change
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			lock_half_r <= 1'b0;
		else if (ce_i)
		begin
			if (mode_nxt == MD_ENG_EXTERNAL && mode_r != MD_ENG_EXTERNAL)
				lock_half_r <= 1'b1;
			else if (wr_ctrl2 && mode_r == MD_ENG_EXTERNAL &&
				wdata_i[C2_MULT_HI:C2_MULT_LO] != mult_factor_field_r)
				lock_half_r <= 1'b1;
			else if (lock_i || mode_r != MD_ENG_EXTERNAL)
				lock_half_r <= 1'b0;
		end
	end
	assign gen_clk_src_o = (mode_r == MD_OFF) ? SRC_NONE : ((mode_r == MD_BYP_EXTERNAL) ? SRC_EXT : SRC_OSC);
	assign gen_clk_rdiv_o      = rdiv_r;
	assign gen_clk_half_o      = lock_half_r && (mode_r == MD_ENG_EXTERNAL);
	assign mult_factor_field_o = mult_factor_field_r;
	// comparisons use predivided internal reference except when engaged-external
	assign cmp_ref_ext_o    = (mode_r == MD_ENG_EXTERNAL);
	assign int_ref_prediv_o = INT_REF_PREDIV;
	assign cmp_periods_o    = (mode_r != MD_ENG_EXTERNAL) ? CMP_INT_PERIODS :
		(range_r ? CMP_EXT_HI_PERIODS : CMP_EXT_LO_PERIODS);
	// Status words; interrupt flag bit shows any pending flag
	assign status_one = {mode_r[1:0], ref_select_r, loss_lock_flag_r, lock_i,
		loss_clock_flag_r, ext_ref_ok, loss_clock_flag_r || loss_lock_flag_r};
	assign status_two = {{(DATA_W-1){1'b0}}, osc_stable_i};
	// Read data registered one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_r <= 8'h00;
		else if (ce_i)
		begin
			rdata_r <= 8'h00;
			if (rd_i)
			begin
				case (addr_i)
					OFS_CONTROL_REG_ONE:
						rdata_r <= {1'b0, range_r, ref_select_r, mode_select_r, 1'b0,
							loss_clock_disable_r, 1'b0};
					OFS_CONTROL_REG_TWO: rdata_r <= {loss_lock_reset_en_r, mult_factor_field_r, loss_clock_reset_en_r, rdiv_r};
					OFS_STATUS_REG_ONE:  rdata_r <= status_one;
					OFS_STATUS_REG_TWO:  rdata_r <= status_two;
					default:             rdata_r <= 8'h00;
				endcase
			end
		end
	end
	assign rdata_o = rdata_r;
endmodule : clm_ctrl

// File: rtl/clm_monitor.sv
// Clock monitoring enables and external-reference-ok resolution
`timescale 1ns/1ns
module clm_monitor
	import clm_pkg::*;
(
	input  wire clm_pkg::clm_mode_t mode_i,
	input  wire logic [1:0]         mode_select_i,
	input  wire logic               ref_type_status_i,
	input  wire logic               loss_clock_disable_i,
	input  wire logic               xtal_startup_i,
	input  wire logic               ext_ref_low_i,
	input  wire logic               osc_wait_i,
	output logic                    ext_ref_ok_o,
	output logic                    ref_mon_o,
	output logic                    osc_mon_o
);

	// Reference ok level and reference monitor enable by mode
	always_comb
	begin
		ext_ref_ok_o = !ext_ref_low_i;
		ref_mon_o    = 1'b0;
		if (!loss_clock_disable_i)
		begin
			if (mode_i == MD_OFF)
			begin
				ref_mon_o    = (mode_select_i == SEL_BYP_EXTERNAL) && ref_type_status_i && xtal_startup_i;
				ext_ref_ok_o = ref_mon_o && !ext_ref_low_i;
			end
			else if (!mode_select_i[1])
				ext_ref_ok_o = 1'b0;
			else if ((mode_select_i == SEL_BYP_EXTERNAL) && !ref_type_status_i)
				ext_ref_ok_o = 1'b1;
			else
			begin
				ref_mon_o    = 1'b1;
				ext_ref_ok_o = !ext_ref_low_i;
			end
		end
	end

	always_comb
	begin
		osc_mon_o = 1'b0;
		if (!loss_clock_disable_i && !osc_wait_i)
			osc_mon_o = (mode_i == MD_SELF_CLOCKED) || (mode_i == MD_ENG_INTERNAL) ||
				(mode_i == MD_ENG_EXTERNAL);
	end

endmodule : clm_monitor

// File: tb/clm_ctrl_assertions.sv
// Concurrent port checks for the clock-loss and mode control block
`timescale 1ns/1ns
module clm_ctrl_assertions
(
	input  wire logic                       sys_clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic                       ce_i,
	input  wire logic [clm_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [clm_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	input  wire logic [clm_pkg::DATA_W-1:0] rdata_o,
	input  wire logic                       ext_ref_low_i,
	input  wire logic                       osc_stable_i,
	input  wire logic [1:0]                 gen_clk_src_o,
	input  wire logic                       gen_clk_half_o,
	input  wire logic                       cmp_ref_ext_o,
	input  wire logic [7:0]                 cmp_periods_o,
	input  wire logic [2:0]                 int_ref_prediv_o,
	input  wire logic                       irq_o,
	input  wire logic                       reset_req_o
);
	import clm_pkg::*;
	logic dis_r;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Shadow of the detect-disable bit, so loss checks skip unmonitored time
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
		if (!reset_n_i)
			dis_r <= 1'b0;
		else if (ce_i && wr_i && addr_i == OFS_CONTROL_REG_ONE)
			dis_r <= wdata_i[C1_LOSS_CLK_DIS_BIT];
	// Read data only in the cycle after a taken read
	rdata_idle_a: assert property (!$past(rd_i && ce_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside read answer");
	osc_status_rd_a: assert property ($past(rd_i && ce_i && addr_i == 2'h3) |-> rdata_o == {7'h00, $past(osc_stable_i)})
		else $error("status two read mismatch");
	prediv_fixed_a: assert property (int_ref_prediv_o == 3'h7)
		else $error("internal predivide not seven");
	int_periods_a: assert property (!cmp_ref_ext_o |-> cmp_periods_o == 8'h08)
		else $error("internal comparison length wrong");
	ext_periods_a: assert property (cmp_ref_ext_o |-> cmp_periods_o inside {8'h02, 8'h80})
		else $error("external comparison length wrong");
	ext_src_a: assert property (gen_clk_src_o == SRC_EXT |-> !cmp_ref_ext_o && !gen_clk_half_o)
		else $error("bypassed mode uses wrong divider");
	half_fee_only_a: assert property (gen_clk_half_o |-> cmp_ref_ext_o && gen_clk_src_o == SRC_OSC)
		else $error("extra halving outside engaged external");
	req_exclusive_a: assert property (reset_req_o |-> !irq_o)
		else $error("interrupt beside reset request");
	fee_fallback_a: assert property (ce_i && cmp_ref_ext_o && ext_ref_low_i && !dis_r |=> !cmp_ref_ext_o)
		else $error("no fallback on reference loss");
	loss_request_a: assert property (ce_i && cmp_ref_ext_o && ext_ref_low_i && !dis_r |-> ##[1:2] (irq_o || reset_req_o))
		else $error("reference loss raised no request");
	// Main scenarios reached
	cov_fallback_c: cover property (cmp_ref_ext_o ##1 !cmp_ref_ext_o);
	cov_reset_req_c: cover property ($rose(reset_req_o));
	cov_half_c: cover property (gen_clk_half_o);
endmodule : clm_ctrl_assertions

bind clm_ctrl clm_ctrl_assertions u_chk (.sys_clk_i, .reset_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.ext_ref_low_i, .osc_stable_i, .gen_clk_src_o, .gen_clk_half_o, .cmp_ref_ext_o, .cmp_periods_o,
	.int_ref_prediv_o, .irq_o, .reset_req_o);

// File: tb/clm_ctrl_tb.sv
// Self-checking bench for the clock-loss and mode control block
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin err_count++; $display("[FAIL] %s exp %h seen %h", n, e, s); end end
module clm_ctrl_tb;
	import clm_pkg::*;
	logic sys_clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_q = 1'b0, lock = 1'b0;
	logic osc_low_i = 1'b0, osc_stable_i = 1'b1, stop_i = 1'b0, dead = 1'b0, ext_low, xtal, half, cext, irq, rreq;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [DATA_W-1:0] wdata_i = '0, rdata, exp_v, rnd;
	logic [DATA_W-1:0] exp_q[$];
	logic [1:0] src;
	logic [2:0] rdiv, mult, pdiv;
	logic [7:0] per;
	int err_count = 0, compares = 0, seed = 75;
	// Clock at 250 MHz
	always #2 sys_clk_i = ~sys_clk_i;
	clm_ctrl dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .ext_ref_low_i(ext_low), .osc_low_i(osc_low_i),
		.osc_stable_i(osc_stable_i), .xtal_startup_i(xtal), .stop_i(stop_i), .lock_i(lock), .lock_lost_i(1'b0),
		.gen_clk_src_o(src), .gen_clk_rdiv_o(rdiv), .gen_clk_half_o(half), .cmp_ref_ext_o(cext),
		.cmp_periods_o(per), .int_ref_prediv_o(pdiv), .mult_factor_field_o(mult), .irq_o(irq), .reset_req_o(rreq));
	clm_ref_model u_ref (.sys_clk_i(sys_clk_i), .dead_i(dead), .stop_i(stop_i), .ext_ref_low_o(ext_low),
		.xtal_startup_o(xtal));
	// Read answers land in the cycle after the strobe; judged mid-cycle against the oldest note
	always @(posedge sys_clk_i)
		rd_q <= rd_i;
	always @(negedge sys_clk_i)
		if (rd_q)
		begin
			exp_v = exp_q.pop_front();
			`CHK("rdata", exp_v, rdata)
		end
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge sys_clk_i);
		exp_q.push_back(e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
	endtask : rd
	// Waits whole cycles, then steps past the edge so outputs have settled
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : wt
	task automatic pulse_reset();
		@(posedge sys_clk_i) reset_n_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
	endtask : pulse_reset
	task automatic wrap_up();
		wt(3);
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	// Watchdog at 10000 cycles, well beyond the roughly 135 cycles of the sequence
	initial
	begin
		#40000;
		err_count++;
		wrap_up();
	end
	initial
	begin
		repeat (3) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		rd(OFS_STATUS_REG_ONE, 8'h00);
		rd(OFS_STATUS_REG_TWO, 8'h01);
		wt(1);
		`CHK("src", SRC_OSC, src)
		// First control write: crystal reference, engaged external
		wr(OFS_CONTROL_REG_ONE, 8'h38);
		rd(OFS_STATUS_REG_ONE, 8'h22);
		wt(8);
		rd(OFS_STATUS_REG_ONE, 8'hE2);
		wt(1);
		`CHK("cmp_ref", 1'b1, cext)
		`CHK("periods", 8'h02, per)
		`CHK("half", 1'b1, half)
		// Lock ends the halved output clock
		@(posedge sys_clk_i) lock <= 1'b1;
		wt(2);
		`CHK("half", 1'b0, half)
		@(posedge sys_clk_i) lock <= 1'b0;
		rnd = 8'($random(seed) & 32'h77);
		wr(OFS_CONTROL_REG_TWO, rnd);
		rd(OFS_CONTROL_REG_TWO, rnd);
		wt(1);
		`CHK("rdiv", rnd[2:0], rdiv)
		`CHK("mult", rnd[6:4], mult)
		// Reference dies while engaged external
		@(posedge sys_clk_i) dead <= 1'b1;
		wt(4);
		`CHK("cmp_ref", 1'b0, cext)
		`CHK("irq", 1'b1, irq)
		rd(OFS_STATUS_REG_ONE, 8'h35);
		rd(OFS_CONTROL_REG_ONE, 8'h20);
		@(posedge sys_clk_i) dead <= 1'b0;
		wt(4);
		rd(OFS_STATUS_REG_ONE, 8'h35);
		wr(OFS_STATUS_REG_ONE, 8'h01);
		rd(OFS_STATUS_REG_ONE, 8'h20);
		wt(1);
		`CHK("irq", 1'b0, irq)
		// Bypassed external, reference select stays locked high
		wr(OFS_CONTROL_REG_ONE, 8'h10);
		wt(8);
		rd(OFS_CONTROL_REG_ONE, 8'h30);
		rd(OFS_STATUS_REG_ONE, 8'hA2);
		wt(1);
		`CHK("src", SRC_EXT, src)
		// Stop forces off; leaving it waits for the crystal start-up window
		@(posedge sys_clk_i) stop_i <= 1'b1;
		wt(2);
		`CHK("src", SRC_NONE, src)
		@(posedge sys_clk_i) stop_i <= 1'b0;
		wt(3);
		`CHK("src", SRC_EXT, src)
		@(posedge sys_clk_i) dead <= 1'b1;
		wt(4);
		`CHK("src", SRC_OSC, src)
		rd(OFS_STATUS_REG_ONE, 8'h25);
		@(posedge sys_clk_i) dead <= 1'b0;
		wr(OFS_STATUS_REG_ONE, 8'h01);
		rd(OFS_STATUS_REG_ONE, 8'h20);
		// Oscillator loss with the loss-of-clock reset enabled
		wr(OFS_CONTROL_REG_TWO, 8'h08);
		@(posedge sys_clk_i) osc_low_i <= 1'b1;
		wt(4);
		`CHK("reset_req", 1'b1, rreq)
		`CHK("irq", 1'b0, irq)
		@(posedge sys_clk_i) osc_low_i <= 1'b0;
		pulse_reset();
		rd(OFS_STATUS_REG_ONE, 8'h00);
		wt(1);
		`CHK("reset_req", 1'b0, rreq)
		// Engaged internal with lock-loss reset only, held off until the oscillator is stable
		@(posedge sys_clk_i) osc_stable_i <= 1'b0;
		wr(OFS_CONTROL_REG_ONE, 8'h08);
		wr(OFS_CONTROL_REG_TWO, 8'h80);
		wt(8);
		rd(OFS_STATUS_REG_ONE, 8'h00);
		@(posedge sys_clk_i) osc_stable_i <= 1'b1;
		wt(2);
		rd(OFS_STATUS_REG_ONE, 8'h40);
		@(posedge sys_clk_i) osc_low_i <= 1'b1;
		wt(4);
		`CHK("reset_req", 1'b1, rreq)
		`CHK("irq", 1'b0, irq)
		`CHK("prediv", 3'h7, pdiv)
		// Clock enable low freezes the registers, so this write is lost
		@(posedge sys_clk_i) ce_i <= 1'b0;
		wr(OFS_CONTROL_REG_TWO, 8'h55);
		ce_i <= 1'b1;
		rd(OFS_CONTROL_REG_TWO, 8'h80);
		wrap_up();
	end
endmodule : clm_ctrl_tb

// File: tb/clm_ref_model.sv
// Behavioural external reference source with a crystal start-up window
`timescale 1ns/1ns
module clm_ref_model
(
	input  wire logic sys_clk_i,
	input  wire logic dead_i,
	input  wire logic stop_i,
	output logic      ext_ref_low_o = 1'b0,
	output logic      xtal_startup_o
);
	logic [3:0] wake_r = 4'h0;
	logic       stop_r = 1'b0;
	// Stopped source reads as too slow, seen by the detector one edge late
	always @(posedge sys_clk_i)
		ext_ref_low_o <= dead_i;
	// Start-up wait runs a while after stop ends
	always @(posedge sys_clk_i)
	begin
		stop_r <= stop_i;
		wake_r <= (stop_r && !stop_i) ? 4'hF : ((wake_r != 4'h0) ? wake_r - 4'h1 : 4'h0);
	end
	assign xtal_startup_o = (wake_r != 4'h0);
endmodule : clm_ref_model
